// *** rtl/can_id_pkg.sv ***
/*
  Constants, types and helpers for the standard identifier buffer block:
  register offsets, field positions, reset values and bit timing.
  Assumes a 100 MHz ref_clk and a byte-addressed AHB-Lite window.
*/
package can_id_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_FREQ_MHZ = 100;
  localparam int unsigned BIT_TIME_NS = 2000;
  localparam int unsigned BIT_CYCLES = (BIT_TIME_NS * CLK_FREQ_MHZ) / 1000;
  localparam logic [7:0] BIT_LAST = 8'(BIT_CYCLES - 1);
  localparam logic [7:0] BIT_SAMPLE = 8'(BIT_CYCLES / 2);
  localparam logic [3:0] IDLE_BITS_LAST = 4'ha;
  localparam int unsigned ID_WIDTH = 11;
  localparam int unsigned ARB_BITS = ID_WIDTH + 2;
  localparam logic [3:0] ARB_LAST = 4'(ARB_BITS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, low eight address bits)
  localparam logic [7:0] OFS_TX_HIGH = 8'h00;
  localparam logic [7:0] OFS_TX_LOW = 8'h04;
  localparam logic [7:0] OFS_TX_UNUSED_A = 8'h08;
  localparam logic [7:0] OFS_TX_UNUSED_B = 8'h0c;
  localparam logic [7:0] OFS_RX_HIGH = 8'h10;
  localparam logic [7:0] OFS_RX_LOW = 8'h14;
  localparam logic [7:0] OFS_RX_UNUSED_A = 8'h18;
  localparam logic [7:0] OFS_RX_UNUSED_B = 8'h1c;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned LOW_ID_MSB = 7;
  localparam int unsigned LOW_ID_LSB = 5;
  localparam int unsigned LOW_RTR_BIT = 4;
  localparam int unsigned LOW_IDE_BIT = 3;
  localparam int unsigned CTRL_TX_REQ_BIT = 0;
  localparam int unsigned CTRL_TX_CANCEL_BIT = 1;
  localparam int unsigned ST_TX_PENDING_BIT = 0;
  localparam int unsigned ST_TX_DONE_BIT = 1;
  localparam int unsigned ST_ARB_LOST_BIT = 2;
  localparam int unsigned ST_RX_FULL_BIT = 3;
  localparam int unsigned ST_BUS_IDLE_BIT = 4;
  localparam int unsigned ST_TX_ACTIVE_BIT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [2:0] FLAGS_RST = 3'h0;

  typedef enum logic [1:0] {ST_WAIT_IDLE, ST_IDLE, ST_SOF, ST_ARB} link_state_type;

  // Arbitration field in wire order: ID10..ID0, remote flag, format flag
  function automatic logic [12:0] arb_field(input logic [7:0] high, input logic [7:0] low);
    arb_field = {high, low[LOW_ID_MSB:LOW_ID_LSB], low[LOW_RTR_BIT], low[LOW_IDE_BIT]};
  endfunction

endpackage

// *** rtl/arb_shifter.sv ***
/*
  Transmit shifter for the arbitration field, most significant bit first.
  Assumes the caller pulses load and shift only at bit boundaries.
*/
`timescale 1ns/10ps
`default_nettype none
module arb_shifter
  import can_id_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic shift,
  input wire logic [12:0] loadBits,
  output logic msbBit,
  output logic nextBit
);

  logic [12:0] shreg_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shreg_ff <= 13'h1fff;
    end else if (load) begin
      shreg_ff <= loadBits;
    end else if (shift) begin
      shreg_ff <= {shreg_ff[11:0], 1'b1};
    end
  end

  assign msbBit = shreg_ff[12];
  assign nextBit = shreg_ff[11];

endmodule
`default_nettype wire

// *** rtl/arb_capture.sv ***
/*
  Receive shifter for the arbitration field seen on the bus.
  Assumes shiftIn pulses once per bit at the sample point.
*/
`timescale 1ns/10ps
`default_nettype none
module arb_capture
  import can_id_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic shiftIn,
  input wire logic bitIn,
  output logic [12:0] bits
);

  logic [12:0] shreg_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shreg_ff <= 13'h0000;
    end else if (shiftIn) begin
      shreg_ff <= {shreg_ff[11:0], bitIn};
    end
  end

  assign bits = shreg_ff;

endmodule
`default_nettype wire

// *** rtl/can_std_id_buffer.sv ***
/*
  Standard-layout identifier buffer for one transmit and one receive buffer,
  with an AHB-Lite register slave and the arbitration-field part of the
  frame logic. Assumes one AHB master, a single 100 MHz clock, and a CAN
  transceiver whose receive pin is asynchronous to ref_clk.
*/
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module can_std_id_buffer
  import can_id_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic canRx,
  output logic canTx
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic canTx_ff;
  logic dataPhase_ff;
  logic dWrite_ff;
  logic [7:0] dAddr_ff;
  logic [7:0] txHigh_ff;
  logic [4:0] txLow_ff;
  logic [7:0] rxHigh_ff;
  logic [4:0] rxLow_ff;
  logic txPending_ff;
  logic txDone_ff;
  logic arbLost_ff;
  logic rxFull_ff;
  logic rxSync1_ff;
  logic rxSync2_ff;
  logic rxSync3_ff;
  logic busBit_ff;
  link_state_type state_ff;
  link_state_type nxt_state;
  logic [7:0] bitCnt_ff;
  logic [7:0] nxt_bitCnt;
  logic [3:0] idleCnt_ff;
  logic [3:0] arbCnt_ff;
  logic transmitting_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire addrAccept = hsel && htrans[1] && hready;
  wire wrStrobe = dataPhase_ff && !hreadyout_ff && dWrite_ff;
  wire wrTxHigh = wrStrobe && (dAddr_ff == OFS_TX_HIGH);
  wire wrTxLow = wrStrobe && (dAddr_ff == OFS_TX_LOW);
  wire wrRxHigh = wrStrobe && (dAddr_ff == OFS_RX_HIGH);
  wire wrRxLow = wrStrobe && (dAddr_ff == OFS_RX_LOW);
  wire wrCtrl = wrStrobe && (dAddr_ff == OFS_CTRL);
  wire wrStatus = wrStrobe && (dAddr_ff == OFS_STATUS);
  wire txReqWr = wrCtrl && hwdata[CTRL_TX_REQ_BIT];
  wire txCancelWr = wrCtrl && hwdata[CTRL_TX_CANCEL_BIT];
  wire clrTxDone = wrStatus && hwdata[ST_TX_DONE_BIT];
  wire clrArbLost = wrStatus && hwdata[ST_ARB_LOST_BIT];
  wire clrRxFull = wrStatus && hwdata[ST_RX_FULL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Read selection; unused fields read as zero
  wire [7:0] txLowRead = {txLow_ff, 3'h0};
  wire [7:0] rxLowRead = {rxLow_ff, 3'h0};
  wire [31:0] statusRead = {26'h0, transmitting_ff, (state_ff == ST_IDLE), rxFull_ff,
                            arbLost_ff, txDone_ff, txPending_ff};
  wire [31:0] rdMux =
    (dAddr_ff == OFS_TX_HIGH) ? {24'h0, txHigh_ff} :
    (dAddr_ff == OFS_TX_LOW) ? {24'h0, txLowRead} :
    (dAddr_ff == OFS_RX_HIGH) ? {24'h0, rxHigh_ff} :
    (dAddr_ff == OFS_RX_LOW) ? {24'h0, rxLowRead} :
    (dAddr_ff == OFS_STATUS) ? statusRead :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: every transfer takes one wait state so that a read
  // right behind a write always sees the new value
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dataPhase_ff <= 1'b0;
      dWrite_ff <= 1'b0;
      dAddr_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= RDATA_RST;
    end else begin
      hresp_ff <= 1'b0;
      if (dataPhase_ff && !hreadyout_ff) begin
        hreadyout_ff <= 1'b1;
        dataPhase_ff <= 1'b0;
        hrdata_ff <= dWrite_ff ? RDATA_RST : rdMux;
      end else if (addrAccept) begin
        dataPhase_ff <= 1'b1;
        hreadyout_ff <= 1'b0;
        dWrite_ff <= hwrite;
        dAddr_ff <= haddr[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; a change counts once stages two and three agree
  wire busStable = (rxSync2_ff == rxSync3_ff);
  wire busFall = busBit_ff && busStable && !rxSync3_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rxSync1_ff <= 1'b1;
      rxSync2_ff <= 1'b1;
      rxSync3_ff <= 1'b1;
      busBit_ff <= 1'b1;
    end else begin
      rxSync1_ff <= canRx;
      rxSync2_ff <= rxSync1_ff;
      rxSync3_ff <= rxSync2_ff;
      if (busStable) begin
        busBit_ff <= rxSync3_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing and link state
  wire bitEnd = (bitCnt_ff == BIT_LAST);
  wire samplePt = (bitCnt_ff == BIT_SAMPLE);
  wire startTx = (state_ff == ST_IDLE) && txPending_ff && !busFall;
  wire startRx = (state_ff == ST_IDLE) && busFall;
  wire arbDone = (state_ff == ST_ARB) && bitEnd && (arbCnt_ff == ARB_LAST);
  wire txMsb;
  wire txNext;
  wire [12:0] capBits;
  // Dominant zero overwrites recessive one, so the lower identifier wins
  wire lostNow = (state_ff == ST_ARB) && samplePt && transmitting_ff &&
                 txMsb && !busBit_ff;
  wire txWon = arbDone && transmitting_ff;
  wire rxLoad = arbDone && !transmitting_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_bitCnt = bitEnd ? 8'h00 : bitCnt_ff + 8'h01;
    case (state_ff)
      ST_WAIT_IDLE: begin
        if (samplePt && busBit_ff && (idleCnt_ff == IDLE_BITS_LAST)) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        nxt_bitCnt = 8'h00;
        if (startRx || startTx) begin
          nxt_state = ST_SOF;
          nxt_bitCnt = 8'h01;
        end
      end
      ST_SOF: begin
        if (bitEnd) begin
          nxt_state = ST_ARB;
        end
      end
      ST_ARB: begin
        if (arbDone) begin
          nxt_state = ST_WAIT_IDLE;
        end
      end
      default: begin
        nxt_state = ST_WAIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= ST_WAIT_IDLE;
      bitCnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
    end
  end

  // Eleven recessive bits mark the bus free; a dominant bit restarts the count
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      idleCnt_ff <= 4'h0;
    end else if (state_ff != ST_WAIT_IDLE) begin
      idleCnt_ff <= 4'h0;
    end else if (samplePt) begin
      idleCnt_ff <= busBit_ff ? idleCnt_ff + 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      arbCnt_ff <= 4'h0;
    end else if (state_ff != ST_ARB) begin
      arbCnt_ff <= 4'h0;
    end else if (bitEnd) begin
      arbCnt_ff <= arbCnt_ff + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side: the field is latched at frame start, so later writes
  // to the transmit registers only affect the next attempt
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      transmitting_ff <= 1'b0;
      canTx_ff <= 1'b1;
    end else if (startTx) begin
      transmitting_ff <= 1'b1;
      canTx_ff <= 1'b0;
    end else if (lostNow || arbDone) begin
      transmitting_ff <= 1'b0;
      canTx_ff <= 1'b1;
    end else if (transmitting_ff && bitEnd) begin
      canTx_ff <= (state_ff == ST_SOF) ? txMsb : txNext;
    end
  end

  arb_shifter txShift (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(startTx),
    .shift((state_ff == ST_ARB) && bitEnd),
    .loadBits(arb_field(txHigh_ff, {txLow_ff, 3'h0})),
    .msbBit(txMsb),
    .nextBit(txNext)
  );

  arb_capture rxShift (
    .ref_clk(ref_clk),
    .reset(reset),
    .shiftIn((state_ff == ST_ARB) && samplePt),
    .bitIn(busBit_ff),
    .bits(capBits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Identifier storage, deliberately without reset
  always_ff @(posedge ref_clk) begin
    if (wrTxHigh) begin
      txHigh_ff <= hwdata[7:0];
    end
    if (wrTxLow) begin
      txLow_ff <= hwdata[LOW_ID_MSB:LOW_IDE_BIT];
    end
  end

  // Frame logic wins over a software write landing in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rxLoad) begin
      rxHigh_ff <= capBits[12:5];
      rxLow_ff <= capBits[4:0];
    end else begin
      if (wrRxHigh) begin
        rxHigh_ff <= hwdata[7:0];
      end
      if (wrRxLow) begin
        rxLow_ff <= hwdata[LOW_ID_MSB:LOW_IDE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; hardware set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      txPending_ff <= 1'b0;
      {txDone_ff, arbLost_ff, rxFull_ff} <= FLAGS_RST;
    end else begin
      if (txWon) begin
        txPending_ff <= 1'b0;
      end else if (txReqWr) begin
        txPending_ff <= 1'b1;
      end else if (txCancelWr && !transmitting_ff) begin
        txPending_ff <= 1'b0;
      end
      txDone_ff <= txWon || (txDone_ff && !clrTxDone);
      arbLost_ff <= lostNow || (arbLost_ff && !clrArbLost);
      rxFull_ff <= rxLoad || (rxFull_ff && !clrRxFull);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign canTx = canTx_ff;

endmodule
`default_nettype wire

// *** tb/can_std_id_buffer_asserts.sv ***
/*
  Port checker for the standard identifier buffer: bus timing and link bit timing.
  Assumes one AHB master, hready tied to hreadyout, one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module can_std_id_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic canTx
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [7:0] bitCnt_ff;
  logic [11:0] sofCnt_ff;
  wire logic taken;
  assign taken = hsel && htrans[1] && hready;
  ////////////////////////////////////////
  // Counters saturate so long idle spans never wrap into a false failure.
  // A lost arbitration releases the pin mid-bit, so only dominant edges
  // are held to bit boundaries.
  always_ff @(posedge ref_clk) begin
    if (reset || $changed(canTx)) begin
      bitCnt_ff <= 8'h00;
    end else if (bitCnt_ff != 8'hff) begin
      bitCnt_ff <= bitCnt_ff + 8'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset || !canTx) begin
      sofCnt_ff <= 12'h000;
    end else if (sofCnt_ff != 12'hfff) begin
      sofCnt_ff <= sofCnt_ff + 12'h001;
    end
  end
  ////////////////////////////////////////
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  property p_wait;
    taken |=> s_wait;
  endproperty
  a_wait: assert property (p_wait) else $error("data phase not two cycles");
  property p_cause;
    !hreadyout |-> $past(taken);
  endproperty
  a_cause: assert property (p_cause) else $error("wait state without transfer");
  property p_hold;
    hreadyout && !taken |=> hreadyout;
  endproperty
  a_hold: assert property (p_hold) else $error("hreadyout dropped while idle");
  property p_rdata;
    !$past(reset) && $changed(hrdata) |-> $rose(hreadyout);
  endproperty
  a_rdata: assert property (p_rdata) else $error("hrdata moved outside a data phase");
  property p_rst;
    $fell(reset) |-> hreadyout && canTx && hrdata == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  property p_bit;
    $fell(canTx) |-> bitCnt_ff >= 8'hc7;
  endproperty
  a_bit: assert property (p_bit) else $error("link bit shorter than a bit time");
  property p_sof;
    $fell(canTx) |-> sofCnt_ff >= 12'h0c7;
  endproperty
  a_sof: assert property (p_sof) else $error("dominant edge after short recessive run");
endmodule
bind can_std_id_buffer can_std_id_checker chk_i (
  .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .canTx(canTx)
);
`default_nettype wire

// *** tb/can_bus_node.sv ***
/*
  Model of another node on the CAN bus, sending one arbitration field on go.
  Assumes the bus is a wired-AND with a recessive pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module can_bus_node
  import can_id_pkg::*;
(
  input wire logic ref_clk,
  input wire logic canTx,
  input wire logic go,
  input wire logic [12:0] frame,
  output logic canRx,
  output logic busy
);
  logic drive;
  // Dominant 0 from either node wins, so the lower identifier survives
  assign canRx = canTx & drive;
  initial begin
    drive = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy <= 1'b1;
        drive <= 1'b0;
        repeat (BIT_CYCLES) @(posedge ref_clk);
        for (int i = 12; i >= 0; i--) begin
          drive <= frame[i];
          repeat (BIT_CYCLES) @(posedge ref_clk);
        end
        drive <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/can_std_id_buffer_tb.sv ***
/*
  Self-checking bench: register map, own frame, lost arbitration and retry.
  Assumes the design, its package, the checker and the bus node model.
*/
`timescale 1ns/10ps
`default_nettype none
module can_std_id_buffer_tb;
  import can_id_pkg::*;
  logic ref_clk, reset, hsel, hwrite, go, canRx, canTx, hreadyout, hresp, busy;
  logic [31:0] haddr, hwdata, hrdata, junk;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [12:0] frame;
  int n_errors = 0;
  int cmp_count = 0;
  can_std_id_buffer can_std_id_buffer_i (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .canRx(canRx), .canTx(canTx)
  );
  can_bus_node can_bus_node_i (
    .ref_clk(ref_clk), .canTx(canTx), .go(go), .frame(frame), .canRx(canRx), .busy(busy)
  );
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask
  task automatic wait_sof();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (canTx !== 1'b0 && n < 6000);
    chk(canTx, 1'b0);
  endtask
  // Sample each bit in its middle, away from the edges
  task automatic bits_chk(input logic [12:0] exp);
    repeat (BIT_CYCLES + BIT_CYCLES / 2 - 1) @(posedge ref_clk);
    for (int i = 12; i >= 0; i--) begin
      chk(canTx, exp[i]);
      repeat (BIT_CYCLES) @(posedge ref_clk);
    end
  endtask
  ////////////////////////////////////////
  task automatic regs_test();
    logic [7:0] zs [6];
    zs = '{OFS_TX_UNUSED_A, OFS_TX_UNUSED_B, OFS_RX_UNUSED_A, OFS_RX_UNUSED_B, OFS_CTRL, 8'h40};
    xfer(1'b1, OFS_TX_HIGH, 32'hdead_00a5, junk);
    xfer(1'b1, OFS_TX_LOW, 32'h0000_00a7, junk);
    xfer(1'b1, OFS_RX_HIGH, 32'h0000_005a, junk);
    rdchk(OFS_RX_HIGH, 32'h0000_005a, 32'hffff_ffff);
    xfer(1'b1, OFS_CTRL, 32'h1, junk);
    rdchk(OFS_STATUS, 32'h1, 32'h1);
    xfer(1'b1, OFS_CTRL, 32'h2, junk);
    rdchk(OFS_STATUS, 32'h0, 32'h1);
    rdchk(OFS_TX_HIGH, 32'h0000_00a5, 32'hffff_ffff);
    rdchk(OFS_TX_LOW, 32'h0000_00a0, 32'hffff_ffff);
    foreach (zs[k]) rdchk(zs[k], 32'h0, 32'hffff_ffff);
  endtask
  task automatic tx_test();
    xfer(1'b1, OFS_CTRL, 32'h1, junk);
    rdchk(OFS_STATUS, 32'h1, 32'h23);
    wait_sof();
    bits_chk({8'ha5, 3'h5, 1'b0, 1'b0});
    rdchk(OFS_STATUS, 32'h2, 32'h3);
    xfer(1'b1, OFS_STATUS, 32'h2, junk);
    rdchk(OFS_STATUS, 32'h0, 32'h2);
  endtask
  // The other node starts with us but carries a smaller identifier
  task automatic arb_test();
    xfer(1'b1, OFS_TX_HIGH, 32'hff, junk);
    xfer(1'b1, OFS_TX_LOW, 32'h18, junk);
    xfer(1'b1, OFS_CTRL, 32'h1, junk);
    frame <= {8'h3c, 3'h2, 1'b1, 1'b1};
    wait_sof();
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    do @(posedge ref_clk); while (busy !== 1'b0);
    rdchk(OFS_RX_HIGH, 32'h3c, 32'hffff_ffff);
    rdchk(OFS_RX_LOW, 32'h58, 32'hffff_ffff);
    rdchk(OFS_STATUS, 32'hd, 32'h2f);
    xfer(1'b1, OFS_STATUS, 32'hc, junk);
    rdchk(OFS_STATUS, 32'h1, 32'hd);
    wait_sof();
    bits_chk({8'hff, 3'h0, 1'b1, 1'b1});
    rdchk(OFS_STATUS, 32'h2, 32'h3);
  endtask
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    go = 1'b0;
    frame = 13'h1fff;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    regs_test();
    tx_test();
    arb_test();
    results();
  end
  // Three frames with their idle gaps need about 15000 cycles
  initial begin
    #500000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
